/* File: amfr_fault_report_control.sv */
// Fault report control bank: masks, hold enables, auto recovery, clear, status.
// Assumes a control port on core_clk_i giving index, data and strobes;
// raw fault sources come from analog monitors and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "amfr_defines.svh"

module amfr_fault_report_control (
  // Clock, reset, enable
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Register port
  input wire amfr_pkg::amfr_reg_req_type reg_req_i,
  output logic [7:0] reg_rdata_o,
  // Raw fault sources, asynchronous
  input wire amfr_pkg::amfr_fault_src_type fault_src_i,
  // Fault report and status
  output logic fault_report_n_o,
  output logic thermal_shutdown_active_o,
  output logic clock_detect_status_o
);

  amfr_pkg::amfr_fault_src_type sync1_q;
  amfr_pkg::amfr_fault_src_type sync2_q;
  logic [7:0] mask_q;
  logic [7:0] latch_q;
  logic [7:0] misc_q;
  logic [6:0] clear_spare_q;
  logic [7:0] rdata_q;
  logic report_n_q;
  logic det_q;
  logic wr_mask;
  logic wr_latch;
  logic wr_misc;
  logic wr_clear;
  logic analog_clear;
  logic thermal_shutdown_fault_flag;
  logic otw_flag;
  logic clk_flag;
  logic [3:0] chan_flag;
  logic [3:0] chan_src;
  logic [8:0] rep_src;
  logic [8:0] rep_en;
  logic report_d;
  logic det_d;
  logic [7:0] rd_mux;
  logic [7:0] chan_status;
  logic [7:0] global1_status;
  logic [7:0] global2_status;
  logic [7:0] warn_status;

  // Two-stage synchroniser; only the second stage feeds logic
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (ce_i) begin
      sync1_q <= fault_src_i;
      sync2_q <= sync1_q;
    end
  end

  // Write decode
  assign wr_mask = reg_req_i.wr && (reg_req_i.addr == `AMFR_OFS_REPORT_MASK);
  assign wr_latch = reg_req_i.wr && (reg_req_i.addr == `AMFR_OFS_LATCH_CONTROL);
  assign wr_misc = reg_req_i.wr && (reg_req_i.addr == `AMFR_OFS_MISC_CONTROL);
  assign wr_clear = reg_req_i.wr && (reg_req_i.addr == `AMFR_OFS_CLEAR_COMMAND);
  assign analog_clear = ce_i && wr_clear && reg_req_i.wdata[`AMFR_BIT_ANALOG_CLEAR];

  // Control registers; reserved bits are stored as plain read/write bits
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mask_q <= `AMFR_RST_REPORT_MASK;
      latch_q <= `AMFR_RST_LATCH_CONTROL;
      misc_q <= `AMFR_RST_MISC_CONTROL;
      clear_spare_q <= 7'(`AMFR_RST_CLEAR_COMMAND); // Bit 7 of the reset value is the unstored clear bit
    end else if (ce_i) begin
      if (wr_mask) mask_q <= reg_req_i.wdata;
      if (wr_latch) latch_q <= reg_req_i.wdata;
      if (wr_misc) misc_q <= reg_req_i.wdata;
      if (wr_clear) clear_spare_q <= reg_req_i.wdata[6:0]; // Clear bit itself is never stored
    end
  end

  // Fault flags with their hold behaviour
  amfr_hold_cell u_thermal_shutdown_fault (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .source_i(sync2_q.thermal_shutdown_fault),
    .hold_en_i(latch_q[`AMFR_BIT_SHUTDOWN_HOLD]),
    .clear_i(analog_clear),
    .auto_release_i(misc_q[`AMFR_BIT_AUTO_RECOVER]),
    .flag_o(thermal_shutdown_fault_flag)
  );

  amfr_hold_cell u_otw (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .source_i(sync2_q.thermal_warning),
    .hold_en_i(latch_q[`AMFR_BIT_WARNING_HOLD]),
    .clear_i(analog_clear),
    .auto_release_i(1'b0),
    .flag_o(otw_flag)
  );

  amfr_hold_cell u_clk (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .source_i(sync2_q.clock_error),
    .hold_en_i(latch_q[`AMFR_BIT_CLOCK_HOLD]),
    .clear_i(analog_clear),
    .auto_release_i(1'b0),
    .flag_o(clk_flag)
  );

  // Output offset and overload flags are always held until the analog clear
  assign chan_src = {sync2_q.left_offset, sync2_q.right_offset, sync2_q.left_overload, sync2_q.right_overload};

  for (genvar g = 0; g < 4; g++) begin : g_chan
    amfr_hold_cell u_chan (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .source_i(chan_src[g]),
      .hold_en_i(1'b1),
      .clear_i(analog_clear),
      .auto_release_i(1'b0),
      .flag_o(chan_flag[g])
    );
  end

  // Report sources lined up with the mask bit positions, warning on top
  assign rep_src = {otw_flag, thermal_shutdown_fault_flag, sync2_q.digital_supply_low, sync2_q.digital_supply_high, clk_flag,
                    sync2_q.power_stage_supply_low, sync2_q.power_stage_supply_high,
                    chan_flag[3] | chan_flag[2], chan_flag[1] | chan_flag[0]};
  assign rep_en = {~latch_q[`AMFR_BIT_WARNING_MASK], ~mask_q};
  assign report_d = |(rep_src & rep_en);

  // Clock detect status follows live unless held; analog clear drops a held copy
  assign det_d = sync2_q.clock_detect | (misc_q[`AMFR_BIT_DETECT_HOLD] & det_q & ~analog_clear);

  // Status images
  assign chan_status = {4'h0, chan_flag};
  assign global1_status = {5'h00, clk_flag, sync2_q.power_stage_supply_high, sync2_q.power_stage_supply_low};
  assign global2_status = {7'h00, thermal_shutdown_fault_flag};
  assign warn_status = {5'h00, otw_flag, 2'h0};

  // Read select; unmapped indexes read as zero, the clear command reads bit 7 as zero
  assign rd_mux = (reg_req_i.addr == `AMFR_OFS_CHANNEL_STATUS) ? chan_status :
                  (reg_req_i.addr == `AMFR_OFS_GLOBAL_STATUS1) ? global1_status :
                  (reg_req_i.addr == `AMFR_OFS_GLOBAL_STATUS2) ? global2_status :
                  (reg_req_i.addr == `AMFR_OFS_WARNING_STATUS) ? warn_status :
                  (reg_req_i.addr == `AMFR_OFS_REPORT_MASK) ? mask_q :
                  (reg_req_i.addr == `AMFR_OFS_LATCH_CONTROL) ? latch_q :
                  (reg_req_i.addr == `AMFR_OFS_MISC_CONTROL) ? misc_q :
                  (reg_req_i.addr == `AMFR_OFS_CLEAR_COMMAND) ? {1'b0, clear_spare_q} :
                  8'h00;

  // Registered outputs; report pin is active low, high means no fault
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
      report_n_q <= 1'b1;
      det_q <= 1'b0;
    end else if (ce_i) begin
      if (reg_req_i.rd) rdata_q <= rd_mux;
      report_n_q <= ~report_d;
      det_q <= det_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign fault_report_n_o = report_n_q;
  assign thermal_shutdown_active_o = thermal_shutdown_fault_flag;
  assign clock_detect_status_o = det_q;

  thermal_shutdown_fault_mask_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && rep_src == 9'h080 && mask_q[7] |=> fault_report_n_o)
    else $error("masked thermal shutdown reported");

  logic_low_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && rep_src == 9'h040 && !mask_q[6] |=> !fault_report_n_o)
    else $error("digital supply low not reported");

  clock_mask_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && rep_src == 9'h010 && mask_q[4] |=> fault_report_n_o)
    else $error("masked clock fault reported");

  power_low_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && rep_src == 9'h008 && !mask_q[3] |=> !fault_report_n_o)
    else $error("power supply low not reported");

  overload_mask_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && rep_src == 9'h001 && mask_q[0] |=> fault_report_n_o)
    else $error("masked overload reported");

  warn_mask_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && rep_src == 9'h100 && latch_q[2] |=> fault_report_n_o)
    else $error("masked thermal warning reported");

  clock_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && clk_flag && latch_q[5] && !analog_clear |=> clk_flag)
    else $error("held clock fault dropped");

  detect_live_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && !misc_q[7] |=> clock_detect_status_o == $past(sync2_q.clock_detect))
    else $error("unheld clock detect not following source");

  auto_recover_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && misc_q[4] && !sync2_q.thermal_shutdown_fault |=> !thermal_shutdown_fault_flag)
    else $error("thermal shutdown did not auto recover");

  analog_clear_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    analog_clear && !sync2_q.thermal_warning |=> !otw_flag)
    else $error("analog clear left warning held");

  chan_read_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && reg_req_i.rd && reg_req_i.addr == `AMFR_OFS_CHANNEL_STATUS |=> reg_rdata_o == {4'h0, $past(chan_flag)})
    else $error("channel status readback wrong");

  warn_read_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && reg_req_i.rd && reg_req_i.addr == `AMFR_OFS_WARNING_STATUS |=> reg_rdata_o[2] == $past(otw_flag))
    else $error("warning status readback wrong");

endmodule // amfr_fault_report_control

`default_nettype wire

/* File: amfr_defines.svh */
// Offsets, field positions, reset values of the fault report control bank.
// Assumes an 8-bit register index and 8-bit data from the control port.
`ifndef AMFR_DEFINES_SVH
`define AMFR_DEFINES_SVH

// Register offsets
`define AMFR_OFS_CHANNEL_STATUS 8'h70
`define AMFR_OFS_GLOBAL_STATUS1 8'h71
`define AMFR_OFS_GLOBAL_STATUS2 8'h72
`define AMFR_OFS_WARNING_STATUS 8'h73
`define AMFR_OFS_REPORT_MASK 8'h74
`define AMFR_OFS_LATCH_CONTROL 8'h75
`define AMFR_OFS_MISC_CONTROL 8'h76
`define AMFR_OFS_CLEAR_COMMAND 8'h78

// Reset values
`define AMFR_RST_REPORT_MASK 8'h00
`define AMFR_RST_LATCH_CONTROL 8'hf8
`define AMFR_RST_MISC_CONTROL 8'h00
`define AMFR_RST_CLEAR_COMMAND 8'h00

// Report mask fields
`define AMFR_BIT_THERMAL_SHUTDOWN_MASK 7
`define AMFR_BIT_LOGIC_LOW_MASK 6
`define AMFR_BIT_LOGIC_HIGH_MASK 5
`define AMFR_BIT_CLOCK_MASK 4
`define AMFR_BIT_POWER_LOW_MASK 3
`define AMFR_BIT_POWER_HIGH_MASK 2
`define AMFR_BIT_OFFSET_MASK 1
`define AMFR_BIT_OVERLOAD_MASK 0

// Latch control fields
`define AMFR_BIT_CLOCK_HOLD 5
`define AMFR_BIT_SHUTDOWN_HOLD 4
`define AMFR_BIT_WARNING_HOLD 3
`define AMFR_BIT_WARNING_MASK 2

// Misc control fields
`define AMFR_BIT_DETECT_HOLD 7
`define AMFR_BIT_AUTO_RECOVER 4

// Clear command field
`define AMFR_BIT_ANALOG_CLEAR 7

// Status fields
`define AMFR_BIT_LEFT_OFFSET 3
`define AMFR_BIT_RIGHT_OFFSET 2
`define AMFR_BIT_LEFT_OVERLOAD 1
`define AMFR_BIT_RIGHT_OVERLOAD 0
`define AMFR_BIT_STATUS_CLOCK 2
`define AMFR_BIT_STATUS_POWER_HIGH 1
`define AMFR_BIT_STATUS_POWER_LOW 0
`define AMFR_BIT_STATUS_SHUTDOWN 0
`define AMFR_BIT_STATUS_WARNING 2

`endif

/* File: amfr_pkg.sv */
// Types shared by the fault report control bank.
// Assumes nothing beyond a SystemVerilog compiler.
package amfr_pkg;

  // Raw fault conditions from the analog monitors
  typedef struct packed {
    logic thermal_shutdown_fault;
    logic thermal_warning;
    logic digital_supply_low;
    logic digital_supply_high;
    logic clock_error;
    logic power_stage_supply_low;
    logic power_stage_supply_high;
    logic left_offset;
    logic right_offset;
    logic left_overload;
    logic right_overload;
    logic clock_detect;
  } amfr_fault_src_type;

  // Register port request from the control port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } amfr_reg_req_type;

endpackage

/* File: amfr_hold_cell.sv */
// One fault flag that either follows its source or holds it until cleared.
// Assumes a source already synchronised to core_clk_i.
`timescale 1ns/1ps
`default_nettype none

module amfr_hold_cell (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Control
  input wire logic source_i,
  input wire logic hold_en_i,
  input wire logic clear_i,
  input wire logic auto_release_i,
  // Flag
  output logic flag_o
);

  logic flag_q;
  logic keep;
  logic flag_d;

  // Source setting wins over a clear in the same cycle
  assign keep = hold_en_i & flag_q & ~clear_i & ~auto_release_i;
  assign flag_d = source_i | keep;
  assign flag_o = flag_q;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      flag_q <= 1'b0;
    end else if (ce_i) begin
      flag_q <= flag_d;
    end
  end

  // A held flag stays until clear or release
  hold_keep_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && flag_q && hold_en_i && !clear_i && !auto_release_i |=> flag_q)
    else $error("held fault flag dropped without clear");

  // Set wins over clear
  set_over_clear_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && source_i && clear_i |=> flag_q)
    else $error("fault event lost in clear cycle");

endmodule // amfr_hold_cell

`default_nettype wire

/* File: amfr_host_model.sv */
// Host model: control port master for the fault report bank.
// Assumes the bank samples requests on the rising edge of core_clk_i.
`timescale 1ns/1ps
`default_nettype none

module amfr_host_model (
  // Clock
  input wire logic core_clk_i,
  // Register port
  output var amfr_pkg::amfr_reg_req_type reg_req_o,
  input wire logic [7:0] reg_rdata_i
);
  initial begin
    reg_req_o = '0;
  end

  // Strobe for one taken edge; released data is inverted so it never looks valid
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk_i);
    reg_req_o <= '{wr: 1'b0, rd: 1'b0, addr: a, wdata: ~d};
  endtask

  // Read data lands on the taken edge and stands until next read; sampled one edge later
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    reg_req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk_i);
    reg_req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
    @(posedge core_clk_i);
    #1 d = reg_rdata_i;
  endtask

  // Analog clear is a write of one to bit 7
  task automatic clear_faults();
    write_reg(8'h78, 8'h80);
  endtask
endmodule // amfr_host_model

`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the fault report control bank.
// Assumes the host model drives the register port; sources are driven here.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic core_clk_i;
  logic rst_i;
  logic ce;
  amfr_pkg::amfr_reg_req_type reg_req;
  amfr_pkg::amfr_fault_src_type src;
  logic [7:0] rdata;
  logic report_n;
  logic ts_active;
  logic det_status;
  logic [7:0] rd;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  // Source bit per report mask bit 0..7, then the warning
  int s_idx [9] = '{2, 4, 5, 6, 7, 8, 9, 11, 10};
  // Held flags: clock, shutdown, warning
  logic [7:0] h_addr [3] = '{8'h71, 8'h72, 8'h73};
  int h_bit [3] = '{2, 0, 2};
  int h_en [3] = '{5, 4, 3};
  int h_src [3] = '{7, 11, 10};

  amfr_fault_report_control u_amfr_fault_report_control (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce), .reg_req_i(reg_req), .reg_rdata_o(rdata),
    .fault_src_i(src), .fault_report_n_o(report_n), .thermal_shutdown_active_o(ts_active),
    .clock_detect_status_o(det_status));
  amfr_host_model u_amfr_host_model (.core_clk_i(core_clk_i), .reg_req_o(reg_req), .reg_rdata_i(rdata));

  // Clock, 25 ns period
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  // Hang guard, well above the expected run
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wcyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    u_amfr_host_model.read_reg(a, rd);
    check(rd, exp);
  endtask

  task automatic raise(input int idx, input logic v);
    @(posedge core_clk_i);
    src <= amfr_pkg::amfr_fault_src_type'(12'(v) << idx);
    wcyc(6);
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    rst_i = 1'b1;
    ce = 1'b1;
    src = '0;
    // Release on an edge so the first request lands a full cycle later
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    wcyc(1);
    // Reset values, status, unmapped index
    check({7'h00, report_n}, 8'h01);
    rchk(8'h74, 8'h00);
    rchk(8'h75, 8'hf8);
    rchk(8'h76, 8'h00);
    rchk(8'h78, 8'h00);
    rchk(8'h77, 8'h00);
    rchk(8'h70, 8'h00);
    rchk(8'h73, 8'h00);
    // Each report mask: reported when clear, suppressed when set
    for (int i = 0; i < 9; i++) begin
      raise(s_idx[i], 1'b1);
      check({7'h00, report_n}, 8'h00);
      raise(s_idx[i], 1'b0);
      u_amfr_host_model.clear_faults();
      wcyc(2);
      check({7'h00, report_n}, 8'h01);
      if (i < 8) u_amfr_host_model.write_reg(8'h74, 8'h01 << i);
      else u_amfr_host_model.write_reg(8'h75, 8'hfc);
      raise(s_idx[i], 1'b1);
      check({7'h00, report_n}, 8'h01);
      raise(s_idx[i], 1'b0);
      u_amfr_host_model.clear_faults();
      u_amfr_host_model.write_reg(8'h74, 8'h00);
      u_amfr_host_model.write_reg(8'h75, 8'hf8);
    end
    // Held flags outlive the source until cleared; released ones track it
    for (int k = 0; k < 3; k++) begin
      raise(h_src[k], 1'b1);
      raise(h_src[k], 1'b0);
      rchk(h_addr[k], 8'h01 << h_bit[k]);
      check({7'h00, report_n}, 8'h00);
      u_amfr_host_model.clear_faults();
      rchk(h_addr[k], 8'h00);
      u_amfr_host_model.write_reg(8'h75, 8'hf8 & ~(8'h01 << h_en[k]));
      raise(h_src[k], 1'b1);
      rchk(h_addr[k], 8'h01 << h_bit[k]);
      raise(h_src[k], 1'b0);
      rchk(h_addr[k], 8'h00);
      u_amfr_host_model.write_reg(8'h75, 8'hf8);
    end
    // Channel flags, write to a status index ignored
    @(posedge core_clk_i);
    src <= amfr_pkg::amfr_fault_src_type'(12'h01e);
    wcyc(6);
    u_amfr_host_model.write_reg(8'h70, 8'h00);
    rchk(8'h70, 8'h0f);
    raise(0, 1'b0);
    u_amfr_host_model.clear_faults();
    rchk(8'h70, 8'h00);
    // Auto recovery releases the shutdown flag
    u_amfr_host_model.write_reg(8'h76, 8'h10);
    raise(11, 1'b1);
    check({7'h00, ts_active}, 8'h01);
    raise(11, 1'b0);
    check({7'h00, ts_active}, 8'h00);
    rchk(8'h72, 8'h00);
    // Clock detect follows live, then held
    u_amfr_host_model.write_reg(8'h76, 8'h00);
    raise(0, 1'b1);
    check({7'h00, det_status}, 8'h01);
    raise(0, 1'b0);
    check({7'h00, det_status}, 8'h00);
    u_amfr_host_model.write_reg(8'h76, 8'h80);
    raise(0, 1'b1);
    raise(0, 1'b0);
    check({7'h00, det_status}, 8'h01);
    u_amfr_host_model.clear_faults();
    wcyc(2);
    check({7'h00, det_status}, 8'h00);
    // Clear bit is not stored, reserved bits are
    u_amfr_host_model.write_reg(8'h78, 8'h85);
    rchk(8'h78, 8'h05);
    // Clock enable low freezes a write; a mid-run reset restores the defaults
    @(posedge core_clk_i);
    ce <= 1'b0;
    u_amfr_host_model.write_reg(8'h74, 8'hff);
    @(posedge core_clk_i);
    ce <= 1'b1;
    rchk(8'h74, 8'h00);
    u_amfr_host_model.write_reg(8'h75, 8'h00);
    rchk(8'h75, 8'h00);
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    @(posedge core_clk_i);
    rst_i <= 1'b0;
    rchk(8'h75, 8'hf8);
    rchk(8'h76, 8'h00);
    final_report();
  end
endmodule // tb_top

`default_nettype wire
